/* File: core/cilt_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cilt_regs.svh"

// What this block does
// - Logic op of accumulator with banked register: one byte, one cycle.
// - Accumulator op from pointer-indirect RAM: one byte, two cycles.
// - Logic op immediate into direct byte: three bytes, three cycles.
// - Accumulator rotates, plain or through carry: one byte, one cycle.
// - Direct to direct byte copy: three bytes, three cycles.
// - Data pointer immediate load: three bytes, three cycles.
// - Code byte move at accumulator plus pointer or counter: one byte, three.
// - External data moves, 8-bit or 16-bit address: one byte, three cycles.
// - Low nibble exchange: one byte, two cycles, upper nibble kept.
// - Carry conditional jumps: two bytes, two cycles untaken, three taken.
// - Bit jumps: three bytes, three or four; test-clear clears set bit.
// - Compare-jump on indirect RAM with immediate: three bytes, four or five.
// - Decrement-jump-nonzero on register: two bytes, two or three cycles.
// - Short absolute call three cycles; long call four cycles.
// - Subroutine and interrupt returns: one byte, five cycles.
// - Taken branches add a penalty when target misses branch target cache.
// - Relative offsets are signed 8-bit, added to next instruction address.
// - Direct address below 0x80 is RAM, at or above is special register.
// - Page target replaces low 11 bits of next instruction address.
// - Full target reaches anywhere in 64K program space.
// - Undefined opcode takes the length, cycle count and branch kind of no-operation.
// - Pointer-indirect uses register 0 or 1 of active bank.
// - Two status word bits select one of four register banks.
// - Conditional branches finish one cycle sooner when not taken.
module cilt_decoder
    import cilt_pkg::*;
(
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    // Instruction issue
    input  wire logic        i_issue,
    input  wire logic [7:0]  i_opcode,
    input  wire logic [7:0]  i_op1,
    input  wire logic [7:0]  i_op2,
    input  wire logic [15:0] i_pc,
    input  wire logic        i_cond_true,
    input  wire logic        i_cache_hit,
    input  wire logic [7:0]  i_psw,
    // Decode results
    output logic [2:0]       o_len,
    output logic [2:0]       o_cycles,
    output logic             o_busy,
    output logic             o_done,
    output logic             o_branch,
    output logic             o_clr_bit,
    output logic             o_sfr_sel,
    output logic [7:0]       o_ram_addr,
    output logic [15:0]      o_target,
    output logic [15:0]      o_next_pc
);

    // Base length and cycle count; bit 6 flags conditional, [5:3] cycles, [2:0] bytes
    function automatic logic [7:0] op_info(input logic [7:0] op);
        logic [3:0] lo;
        logic [3:0] hi;
        logic [2:0] b;
        logic [2:0] c;
        logic       cnd;
        lo  = op[3:0];
        hi  = op[7:4];
        b   = 3'h1;
        c   = 3'h1;
        cnd = 1'b0;
        if (op == `CILT_OP_UNDEF) begin
            b = 3'h1;
            c = 3'h1;
        end else if (lo[3]) begin
            // Banked register forms
            case (hi)
                4'h7, 4'ha, 4'h8: begin b = 3'h2; c = 3'h2; end
                4'hb:             begin b = 3'h3; c = 3'h3; cnd = 1'b1; end
                4'hd:             begin b = 3'h2; c = 3'h2; cnd = 1'b1; end
                default:          begin b = 3'h1; c = 3'h1; end
            endcase
        end else if (lo == 4'h6 || lo == 4'h7) begin
            // Pointer-indirect forms
            case (hi)
                4'h7, 4'ha, 4'h8: begin b = 3'h2; c = 3'h2; end
                4'hb:    begin b = 3'h3; c = 3'h4; cnd = 1'b1; end
                4'hd:    begin b = 3'h1; c = 3'h2; end
                4'hf:    begin b = 3'h1; c = 3'h2; end
                default: begin b = 3'h1; c = 3'h2; end
            endcase
        end else if (lo == 4'h1) begin
            b = 3'h2;
            c = hi[0] ? 3'h3 : 3'h3;
        end else begin
            case (op)
                8'h00, 8'h03, 8'h13, 8'h23, 8'h33, 8'h04, 8'h14, 8'hc4, 8'hd4,
                8'he4, 8'hf4, 8'hc3, 8'hd3, 8'hb3, 8'ha3: begin
                    b = 3'h1; c = 3'h1;
                end
                8'h02, 8'h12: begin b = 3'h3; c = 3'h4; end
                8'h22, 8'h32: begin b = 3'h1; c = 3'h5; end
                8'h80, 8'h73: begin b = op[7] ? 3'h2 : 3'h1; c = 3'h3; end
                8'h40, 8'h50, 8'h60, 8'h70: begin
                    b = 3'h2; c = 3'h2; cnd = 1'b1;
                end
                8'h10, 8'h20, 8'h30: begin
                    b = 3'h3; c = 3'h3; cnd = 1'b1;
                end
                8'hb4, 8'hb5, 8'hd5: begin b = 3'h3; c = 3'h3; cnd = 1'b1; end
                8'h43, 8'h53, 8'h63, 8'h85, 8'h75: begin
                    b = 3'h3; c = 3'h3;
                end
                8'h90: begin b = 3'h3; c = 3'h3; end
                8'h83, 8'h93, 8'he0, 8'hf0, 8'he2, 8'he3, 8'hf2, 8'hf3: begin
                    b = 3'h1; c = 3'h3;
                end
                8'ha4: begin b = 3'h1; c = 3'h4; end
                8'h84: begin b = 3'h1; c = 3'h7; end // Longest count the field holds
                8'ha2, 8'h92, 8'h72, 8'h82, 8'ha0, 8'hb0, 8'hb2, 8'hc2, 8'hd2,
                8'h42, 8'h52, 8'h62, 8'h74, 8'h24, 8'h34, 8'h44, 8'h54, 8'h64,
                8'h94, 8'h05, 8'h15, 8'h25, 8'h35, 8'h45, 8'h55, 8'h65, 8'h95,
                8'hc5, 8'he5, 8'hf5, 8'hc0, 8'hd0: begin
                    b = 3'h2; c = 3'h2;
                end
                default: begin b = 3'h1; c = 3'h1; end
            endcase
        end
        op_info = {1'b0, cnd, c, b};
    endfunction

    // Branch kind of an opcode
    function automatic cilt_br_t br_kind(input logic [7:0] op);
        logic [7:0] inf;
        inf = op_info(op);
        if (op[4:0] == 5'h01 || op[4:0] == 5'h11)
            br_kind = CILT_BR_ABS;
        else if (op == 8'h02 || op == 8'h12)
            br_kind = CILT_BR_LONG;
        else if (op == 8'h22 || op == 8'h32)
            br_kind = CILT_BR_RET;
        else if (op == 8'h73)
            br_kind = CILT_BR_IND;
        else if (op == 8'h80)
            br_kind = CILT_BR_REL;
        else if (inf[6])
            br_kind = CILT_BR_COND;
        else
            br_kind = CILT_BR_NONE;
    endfunction

    cilt_st_t    st_reg;
    cilt_st_t    st_next;
    logic [7:0]  info;
    cilt_br_t    kind;
    logic [15:0] seq_pc;
    logic [7:0]  rel_off;
    logic [2:0]  base_cyc;
    logic [1:0]  bank;
    logic        taken;

    always_comb begin
        st_next  = st_reg;
        info     = op_info(i_opcode);
        kind     = br_kind(i_opcode);
        seq_pc   = i_pc + {13'h0, info[2:0]};
        base_cyc = info[5:3];
        bank     = {i_psw[`CILT_BANK_HI_BIT], i_psw[`CILT_BANK_LO_BIT]};
        rel_off  = (kind == CILT_BR_COND && info[2:0] == 3'h3) ? i_op2 : i_op1;
        taken    = (kind != CILT_BR_NONE && kind != CILT_BR_COND) || i_cond_true;
        st_next.done = 1'b0;
        case (st_reg.state)
            CILT_IDLE, CILT_DONE: begin
                st_next.state = CILT_IDLE;
                st_next.busy  = 1'b0;
                if (i_issue) begin
                    st_next.len       = info[2:0];
                    st_next.is_branch = taken && kind != CILT_BR_NONE;
                    st_next.cyc       = base_cyc;
                    if (kind == CILT_BR_COND && i_cond_true)
                        st_next.cyc = base_cyc + 3'h1;
                    if (taken && kind != CILT_BR_NONE && !i_cache_hit)
                        st_next.cyc = st_next.cyc + `CILT_MISS_PENALTY;
                    st_next.clr_bit = (i_opcode == 8'h10) && i_cond_true;
                    st_next.sfr_sel = i_op1 >= `CILT_SFR_BASE;
                    // Register address inside active bank; indirect picks R0 or R1
                    st_next.ram_addr = {3'h0, bank,
                        (i_opcode[3:1] == 3'h3 && !i_opcode[3]) ?
                        {2'h0, i_opcode[0]} : i_opcode[2:0]};
                    st_next.next_pc = seq_pc;
                    case (kind)
                        CILT_BR_ABS:
                            st_next.target = {seq_pc[15:`CILT_PAGE_BITS],
                                              i_opcode[7:5], i_op1};
                        CILT_BR_LONG:
                            st_next.target = {i_op1, i_op2};
                        CILT_BR_REL, CILT_BR_COND:
                            st_next.target = seq_pc + {{8{rel_off[7]}}, rel_off};
                        default:
                            st_next.target = seq_pc;
                    endcase
                    st_next.cnt   = 3'h1;
                    st_next.busy  = 1'b1;
                    st_next.state = CILT_EXEC;
                    if (st_next.cyc == 3'h1) begin
                        st_next.busy  = 1'b0;
                        st_next.done  = 1'b1;
                        st_next.state = CILT_DONE;
                    end
                end
            end
            CILT_EXEC: begin
                st_next.cnt = st_reg.cnt + 3'h1;
                if (st_next.cnt == st_reg.cyc) begin
                    st_next.busy  = 1'b0;
                    st_next.done  = 1'b1;
                    st_next.state = CILT_DONE;
                end
            end
            default: st_next.state = CILT_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign o_len      = st_reg.len;
    assign o_cycles   = st_reg.cyc;
    assign o_busy     = st_reg.busy;
    assign o_done     = st_reg.done;
    assign o_branch   = st_reg.is_branch;
    assign o_clr_bit  = st_reg.clr_bit;
    assign o_sfr_sel  = st_reg.sfr_sel;
    assign o_ram_addr = st_reg.ram_addr;
    assign o_target   = st_reg.target;
    assign o_next_pc  = st_reg.next_pc;

    logic idle_iss;
    assign idle_iss = i_issue && !st_reg.busy;

    rot_one_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        idle_iss && i_opcode == 8'h23 |=> o_len == 3'h1 && o_done)
        else $error("rotate not one byte one cycle");
    nop_alias_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        idle_iss && i_opcode == 8'ha5 |=> o_len == 3'h1 && o_cycles == 3'h1)
        else $error("undefined opcode not like nop");
    ret_five_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        idle_iss && i_opcode == 8'h22 && i_cache_hit |=> o_busy [*4] ##1 o_done)
        else $error("return not five cycles");
    xdata_three_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        idle_iss && i_opcode == 8'he0 |=> o_cycles == 3'h3 && o_len == 3'h1)
        else $error("external move timing wrong");
    compare_jump_unequal_ind_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        idle_iss && i_opcode == 8'hb6 && !i_cond_true |=> o_cycles == 3'h4)
        else $error("compare jump untaken not four");
    cond_taken_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        idle_iss && i_opcode == 8'h40 && i_cond_true && i_cache_hit
        |=> o_cycles == 3'h3 && o_branch)
        else $error("taken carry jump not three");
    page_target_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        idle_iss && i_opcode == 8'h11 |=> o_target[15:11] == o_next_pc[15:11])
        else $error("page target left page");
    miss_pen_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        idle_iss && i_opcode == 8'h02 && !i_cache_hit |=> o_cycles == 3'h6)
        else $error("miss penalty missing");
    bank_sel_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        idle_iss && i_opcode == 8'h28 |=> o_ram_addr[4:3] == $past(i_psw[4:3]))
        else $error("bank select wrong");

    // Length and base timing per instruction class
    reg_logic_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        idle_iss && i_opcode == 8'h5d |=> o_len == 3'h1 && o_cycles == 3'h1 && o_done)
        else $error("register logic op not one byte one cycle");
    ind_acc_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        idle_iss && i_opcode == 8'h57 |=> o_len == 3'h1 && o_cycles == 3'h2 && o_busy)
        else $error("indirect accumulator op not one byte two cycles");
    imm_direct_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        idle_iss && i_opcode == 8'h43 |=> o_len == 3'h3 && o_cycles == 3'h3)
        else $error("immediate to direct op not three and three");
    dir_copy_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        idle_iss && i_opcode == 8'h85 |=> o_len == 3'h3 && o_cycles == 3'h3)
        else $error("direct copy not three and three");
    ptr_load_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        idle_iss && i_opcode == 8'h90 |=> o_len == 3'h3 && o_cycles == 3'h3)
        else $error("data pointer load not three and three");
    code_move_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        idle_iss && (i_opcode == 8'h83 || i_opcode == 8'h93)
        |=> o_len == 3'h1 && o_cycles == 3'h3)
        else $error("code byte move not one byte three cycles");
    nibble_xchg_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        idle_iss && i_opcode[7:1] == 7'h6b |=> o_len == 3'h1 && o_cycles == 3'h2)
        else $error("low nibble exchange not one byte two cycles");
    carry_fall_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        idle_iss && i_opcode == 8'h40 && !i_cond_true
        |=> o_len == 3'h2 && o_cycles == 3'h2 && !o_branch)
        else $error("untaken carry jump not two and two");
    bit_fall_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        idle_iss && i_opcode == 8'h10 && !i_cond_true
        |=> o_len == 3'h3 && o_cycles == 3'h3 && !o_clr_bit)
        else $error("untaken bit jump not three and three");
    bit_clear_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        idle_iss && i_opcode == 8'h10 && i_cond_true |=> o_clr_bit)
        else $error("test and clear did not clear bit");
    decrement_jump_nonzero_taken_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        idle_iss && i_opcode == 8'hd8 && i_cond_true && i_cache_hit
        |=> o_len == 3'h2 && o_cycles == 3'h3 && o_branch)
        else $error("taken register decrement jump not three");
    short_call_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        idle_iss && i_opcode == 8'h11 && i_cache_hit |=> o_len == 3'h2 && o_cycles == 3'h3)
        else $error("short call not three cycles");
    long_call_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        idle_iss && i_opcode == 8'h12 && i_cache_hit |=> o_len == 3'h3 && o_cycles == 3'h4)
        else $error("long call not four cycles");
    compare_jump_unequal_taken_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        idle_iss && i_opcode == 8'hb6 && i_cond_true && i_cache_hit |=> o_cycles == 3'h5)
        else $error("taken indirect compare jump not five");
    size_known_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        idle_iss |=> o_len != 3'h0 && o_cycles != 3'h0)
        else $error("opcode without length or cycle count");
    busy_ignore_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_issue && o_busy |=> $stable(o_len) && $stable(o_cycles) && $stable(o_target))
        else $error("request taken while busy");

    // Operand forms and targets
    rel_target_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        idle_iss && i_opcode == 8'h80
        |=> o_target == $past(i_pc) + 16'h0002 + {{8{$past(i_op1[7])}}, $past(i_op1)})
        else $error("relative target not from next instruction");
    sfr_split_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        idle_iss |=> o_sfr_sel == $past(i_op1[7]))
        else $error("direct address space split wrong");
    long_target_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        idle_iss && i_opcode == 8'h02 |=> o_target == {$past(i_op1), $past(i_op2)})
        else $error("full target not taken whole");
    ind_reg_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        idle_iss && i_opcode[3:1] == 3'h3 |=> o_ram_addr[2:0] == {2'h0, $past(i_opcode[0])})
        else $error("indirect pointer not first or second register");

    c_cond_c: cover property (@(posedge i_mclk) idle_iss && i_opcode == 8'h40 && i_cond_true);
    c_ret_c: cover property (@(posedge i_mclk) idle_iss && i_opcode == 8'h32);
    c_miss_c: cover property (@(posedge i_mclk) idle_iss && !i_cache_hit && i_opcode == 8'h80);
    c_decrement_jump_nonzero_c: cover property (@(posedge i_mclk) idle_iss && i_opcode == 8'hd8 && i_cond_true);
    c_refuse_c: cover property (@(posedge i_mclk) i_issue && o_busy);

endmodule // cilt_decoder
`default_nettype wire

/* File: pkg/cilt_pkg.sv */
package cilt_pkg;
    typedef enum logic [1:0] {
        CILT_IDLE = 2'b00,
        CILT_EXEC = 2'b01,
        CILT_DONE = 2'b11
    } cilt_state_t;

    typedef enum logic [2:0] {
        CILT_BR_NONE = 3'h0,
        CILT_BR_COND = 3'h1,
        CILT_BR_ABS  = 3'h2,
        CILT_BR_LONG = 3'h3,
        CILT_BR_REL  = 3'h4,
        CILT_BR_RET  = 3'h5,
        CILT_BR_IND  = 3'h6
    } cilt_br_t;

    typedef struct packed {
        cilt_state_t state;
        logic [2:0]  len;
        logic [2:0]  cyc;
        logic [2:0]  cnt;
        logic        busy;
        logic        done;
        logic        is_branch;
        logic        clr_bit;
        logic        sfr_sel;
        logic [7:0]  ram_addr;
        logic [15:0] target;
        logic [15:0] next_pc;
    } cilt_st_t;
endpackage

/* File: pkg/cilt_regs.svh */
`ifndef CILT_REGS_SVH
`define CILT_REGS_SVH

// Status word bank select bit positions
`define CILT_BANK_LO_BIT       3
`define CILT_BANK_HI_BIT       4
// Direct address split: at or above this is special function space
`define CILT_SFR_BASE          8'h80
// Page mask for short absolute targets (11 bits)
`define CILT_PAGE_BITS         11
// Undefined opcode treated as no-operation
`define CILT_OP_UNDEF          8'ha5
`define CILT_OP_NOP            8'h00
// Extra cycles charged on a branch target cache miss
`define CILT_MISS_PENALTY      3'h2
// Clock period in ns (25 MHz)
`define CILT_CLK_NS            40

`endif

/* File: test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import cilt_pkg::*;
    logic        i_mclk;
    logic        i_rst_n;
    logic        i_issue;
    logic [7:0]  i_opcode;
    logic [7:0]  i_op1;
    logic [7:0]  i_op2;
    logic [15:0] i_pc;
    logic        i_cond_true;
    logic        i_cache_hit;
    logic [7:0]  i_psw;
    logic [2:0]  o_len;
    logic [2:0]  o_cycles;
    logic        o_busy;
    logic        o_done;
    logic        o_branch;
    logic        o_clr_bit;
    logic        o_sfr_sel;
    logic [7:0]  o_ram_addr;
    logic [15:0] o_target;
    logic [15:0] o_next_pc;
    int          err_count;
    int          tests_run;

    cilt_decoder i_cilt_decoder (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_issue(i_issue), .i_opcode(i_opcode),
        .i_op1(i_op1), .i_op2(i_op2), .i_pc(i_pc), .i_cond_true(i_cond_true),
        .i_cache_hit(i_cache_hit), .i_psw(i_psw), .o_len(o_len), .o_cycles(o_cycles),
        .o_busy(o_busy), .o_done(o_done), .o_branch(o_branch), .o_clr_bit(o_clr_bit),
        .o_sfr_sel(o_sfr_sel), .o_ram_addr(o_ram_addr), .o_target(o_target),
        .o_next_pc(o_next_pc)
    );

    initial begin
        i_mclk = 1'b0;
        forever #20 i_mclk = ~i_mclk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Issue one instruction, count edges to the done pulse, check timing and length
    task automatic run(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b,
                       input logic [15:0] pc, input logic c, input logic h,
                       input logic [2:0] el, input logic [2:0] ec, input logic inj);
        int n;
        n = 0;
        @(posedge i_mclk);
        i_issue <= 1'b1;
        i_opcode <= op;
        i_op1 <= a;
        i_op2 <= b;
        i_pc <= pc;
        i_cond_true <= c;
        i_cache_hit <= h;
        @(posedge i_mclk);
        i_issue <= 1'b0;
        // Request taken at this edge; a one-cycle op shows done right after it
        n = 1;
        #1;
        while (o_done !== 1'b1 && n < 12) begin
            @(posedge i_mclk);
            // Optional request while busy, must be ignored
            i_issue <= inj && n == 1;
            i_opcode <= inj ? 8'h43 : op;
            n++;
            #1;
        end
        chk(n[15:0], {13'h0000, ec});
        chk({13'h0000, o_len}, {13'h0000, el});
        chk({13'h0000, o_cycles}, {13'h0000, ec});
        chk(o_next_pc, pc + {13'h0000, el});
        chk({15'h0000, o_busy}, 16'h0000);
    endtask

    task automatic t_logic();
        @(posedge i_mclk) i_psw <= 8'h10;
        run(8'h5d, 8'h00, 8'h00, 16'h0100, 1'b0, 1'b1, 3'h1, 3'h1, 1'b0);
        chk({8'h00, o_ram_addr}, 16'h0015);
        @(posedge i_mclk) i_psw <= 8'h18;
        run(8'h57, 8'h00, 8'h00, 16'h0200, 1'b0, 1'b1, 3'h1, 3'h2, 1'b0);
        chk({8'h00, o_ram_addr}, 16'h0019);
        run(8'h28, 8'h00, 8'h00, 16'h0210, 1'b0, 1'b1, 3'h1, 3'h1, 1'b0);
        chk({8'h00, o_ram_addr}, 16'h0018);
        run(8'h43, 8'h80, 8'h0f, 16'h0300, 1'b0, 1'b1, 3'h3, 3'h3, 1'b0);
        chk({15'h0000, o_sfr_sel}, 16'h0001);
        run(8'h43, 8'h7f, 8'h0f, 16'h0310, 1'b0, 1'b1, 3'h3, 3'h3, 1'b0);
        chk({15'h0000, o_sfr_sel}, 16'h0000);
        $display("test logic finished");
    endtask

    task automatic t_simple();
        logic [7:0] ops [4] = '{8'h23, 8'h33, 8'h03, 8'h13};
        logic [7:0] mv [4] = '{8'he0, 8'he2, 8'hf0, 8'hf2};
        foreach (ops[k]) begin
            run(ops[k], 8'h00, 8'h00, 16'h0400, 1'b0, 1'b1, 3'h1, 3'h1, 1'b0);
            run(mv[k], 8'h00, 8'h00, 16'h0410, 1'b0, 1'b1, 3'h1, 3'h3, 1'b0);
        end
        run(8'ha5, 8'h00, 8'h00, 16'h0420, 1'b0, 1'b1, 3'h1, 3'h1, 1'b0);
        chk({15'h0000, o_branch}, 16'h0000);
        run(8'h85, 8'h30, 8'h90, 16'h0430, 1'b0, 1'b1, 3'h3, 3'h3, 1'b0);
        run(8'h90, 8'h12, 8'h34, 16'h0440, 1'b0, 1'b1, 3'h3, 3'h3, 1'b0);
        run(8'h93, 8'h00, 8'h00, 16'h0450, 1'b0, 1'b1, 3'h1, 3'h3, 1'b0);
        run(8'h83, 8'h00, 8'h00, 16'h0460, 1'b0, 1'b1, 3'h1, 3'h3, 1'b0);
        run(8'hd6, 8'h00, 8'h00, 16'h0470, 1'b0, 1'b1, 3'h1, 3'h2, 1'b0);
        $display("test simple finished");
    endtask

    task automatic t_cond();
        run(8'h40, 8'hf0, 8'h00, 16'h1000, 1'b0, 1'b1, 3'h2, 3'h2, 1'b0);
        run(8'h40, 8'hf0, 8'h00, 16'h1000, 1'b1, 1'b1, 3'h2, 3'h3, 1'b0);
        chk(o_target, 16'h0ff2);
        chk({15'h0000, o_branch}, 16'h0001);
        run(8'h40, 8'h10, 8'h00, 16'h1000, 1'b1, 1'b0, 3'h2, 3'h5, 1'b0);
        run(8'h10, 8'h21, 8'h05, 16'h2000, 1'b1, 1'b1, 3'h3, 3'h4, 1'b0);
        chk({15'h0000, o_clr_bit}, 16'h0001);
        chk(o_target, 16'h2008);
        run(8'h10, 8'h21, 8'h05, 16'h2000, 1'b0, 1'b1, 3'h3, 3'h3, 1'b0);
        chk({15'h0000, o_clr_bit}, 16'h0000);
        run(8'hb6, 8'h55, 8'h80, 16'h3000, 1'b0, 1'b1, 3'h3, 3'h4, 1'b0);
        run(8'hb6, 8'h55, 8'h80, 16'h3000, 1'b1, 1'b1, 3'h3, 3'h5, 1'b0);
        chk(o_target, 16'h2f83);
        run(8'hd8, 8'h04, 8'h00, 16'h4000, 1'b0, 1'b1, 3'h2, 3'h2, 1'b0);
        run(8'hd8, 8'h04, 8'h00, 16'h4000, 1'b1, 1'b1, 3'h2, 3'h3, 1'b0);
        $display("test conditional finished");
    endtask

    task automatic t_call();
        run(8'h11, 8'h34, 8'h00, 16'h07fe, 1'b0, 1'b1, 3'h2, 3'h3, 1'b0);
        chk(o_target, 16'h0834);
        run(8'h12, 8'hbe, 8'hef, 16'h0010, 1'b0, 1'b1, 3'h3, 3'h4, 1'b0);
        chk(o_target, 16'hbeef);
        run(8'h22, 8'h00, 8'h00, 16'h0500, 1'b0, 1'b1, 3'h1, 3'h5, 1'b1);
        run(8'h32, 8'h00, 8'h00, 16'h0510, 1'b0, 1'b1, 3'h1, 3'h5, 1'b0);
        run(8'h80, 8'hfe, 8'h00, 16'h0600, 1'b0, 1'b0, 3'h2, 3'h5, 1'b0);
        chk(o_target, 16'h0600);
        run(8'h02, 8'h12, 8'h34, 16'h0020, 1'b0, 1'b0, 3'h3, 3'h6, 1'b0);
        chk(o_target, 16'h1234);
        run(8'h73, 8'h00, 8'h00, 16'h0700, 1'b0, 1'b1, 3'h1, 3'h3, 1'b0);
        chk({15'h0000, o_branch}, 16'h0001);
        $display("test call and return finished");
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        err_count = 0;
        tests_run = 0;
        i_rst_n = 1'b0;
        i_issue = 1'b0;
        i_opcode = 8'h00;
        i_op1 = 8'h00;
        i_op2 = 8'h00;
        i_pc = 16'h0000;
        i_cond_true = 1'b0;
        i_cache_hit = 1'b1;
        i_psw = 8'h00;
        repeat (10) @(posedge i_mclk);
        #1;
        chk({14'h0000, o_busy, o_done}, 16'h0000);
        @(posedge i_mclk) i_rst_n <= 1'b1;
        t_logic();
        t_simple();
        t_cond();
        t_call();
        stop_test();
    end

    // Hang guard, well beyond the roughly 150 cycles the tests need
    initial begin
        repeat (5000) @(posedge i_mclk);
        err_count++;
        stop_test();
    end
endmodule // tb
`default_nettype wire
